// ---- verilog/loop_eval_defs.svh ----
/*
  Constants of the per-channel vehicle evaluation: reset values,
  correction limits and timing counts. Assumes a 20 MHz ref_clk.
*/
`ifndef LOOP_EVAL_DEFS_SVH
`define LOOP_EVAL_DEFS_SVH

// clock rate and derived second
`define REF_CLK_HZ 20000000
`define SEC_CYCLES (`REF_CLK_HZ * 1)

// sensitivity recovery after a stuck vehicle leaves, in seconds
`define RECOVERY_TIME_S 4
`define RECOVERY_SECS 8'(`RECOVERY_TIME_S)

// length correction, decimetres
`define LEN_CORR_MAX 5'd20
`define LEN_CORR_DEF_TYPE0 5'd10
`define LEN_CORR_DEF_TYPE1 5'd12
`define LEN_CORR_DEF_TYPE2 5'd14
`define LEN_CORR_DEF_TYPE3 5'd10

// reset values of configuration, and the hold diagnostic count limit
`define MIN_SPEED_RST 8'd20
`define HOLD_SECS_RST 8'd0
`define HOLD_INF_RST 1'b1
`define BUS_ADDR_RST 8'h01
`define DIAG_MAX 16'hffff

`endif

// ---- verilog/loop_eval_pkg.sv ----
/*
  Types of the per-channel vehicle evaluation.
  Assumes loop_eval_defs.svh is included by the design files.
*/
package loop_eval_pkg;

  typedef enum logic [1:0] {
    DIR_OFF = 2'b00,
    DIR_FWD = 2'b01,
    DIR_REV = 2'b10
  } dir_mode_t;

  typedef enum logic {
    TAG_NORMAL = 1'b0,
    TAG_WRONG = 1'b1
  } dir_tag_t;

  typedef enum logic [3:0] {
    SUP_FREE = 4'b0001,
    SUP_OCC = 4'b0010,
    SUP_STUCK = 4'b0100,
    SUP_RECOVER = 4'b1000
  } sup_state_t;

  // order: 0 = channel 1 to 2, 1 = channel 2 to 1
  typedef struct packed {
    logic order;
    logic [9:0] atten_len;
    logic [7:0] speed;
  } veh_in_t;

  typedef struct packed {
    logic wrong_way;
    logic order;
    logic [9:0] real_len;
    logic [7:0] speed;
  } telegram_t;

  typedef struct packed {
    dir_tag_t tag;
    logic suffix;
  } svc_line_t;

  typedef struct packed {
    logic [1:0] loop_type;
    logic [4:0] len_corr;
    logic [7:0] min_speed;
    dir_mode_t dir_mode;
    logic [7:0] hold_secs;
    logic hold_inf;
    logic [7:0] bus_addr;
  } cfg_t;

endpackage : loop_eval_pkg

// ---- verilog/length_corrector.sv ----
/*
  Attenuation length to real length, saturating at zero.
  Pure combinational; the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none
`include "loop_eval_defs.svh"

module length_corrector
  import loop_eval_pkg::*;
(
  input wire logic [9:0] atten_len,
  input wire logic [4:0] len_corr,
  output logic [9:0] real_len
);

  logic [9:0] corr_w;

  always_comb begin
    corr_w = {5'h00, len_corr};
    if (corr_w > atten_len) begin
      real_len = 10'h000;
    end else begin
      real_len = atten_len - corr_w;
    end
  end

endmodule : length_corrector

`default_nettype wire

// ---- verilog/hold_supervisor.sv ----
/*
  Hold timer and sensitivity recovery of one channel.
  occupied comes from same-clock detection logic.
*/
`timescale 1ns/1ns
`default_nettype none
`include "loop_eval_defs.svh"

module hold_supervisor
  import loop_eval_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SEC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic occupied,
  input wire logic [7:0] hold_secs,
  input wire logic hold_inf,
  output logic chan_reset,
  output logic ignore_veh,
  output logic sens_reduced,
  output logic [15:0] diag_count
);

  typedef struct packed {
    sup_state_t state;
    logic occ_prev;
    logic [24:0] pre;
    logic [7:0] secs;
    logic reduced;
    logic reset_pulse;
    logic [15:0] diag;
  } sup_t;

  sup_t s_q, s_d;
  logic tick;
  logic rise;
  logic fall;
  logic finite;

  assign tick = (s_q.pre == 25'(SEC_CYCLES - 1));
  assign rise = occupied && !s_q.occ_prev;
  assign fall = !occupied && s_q.occ_prev;
  // zero seconds counts as static as well
  assign finite = !hold_inf && (hold_secs != 8'h00);

  always_comb begin
    s_d = s_q;
    s_d.occ_prev = occupied;
    s_d.reset_pulse = 1'b0;
    s_d.pre = tick ? 25'h0000000 : s_q.pre + 25'h0000001;
    if (tick) begin
      s_d.secs = (s_q.secs == 8'hff) ? s_q.secs : s_q.secs + 8'h01;
    end
    case (s_q.state)
      SUP_FREE: begin
        if (rise) begin
          s_d.state = SUP_OCC;
          s_d.pre = 25'h0000000;
          s_d.secs = 8'h00;
        end
      end
      SUP_OCC: begin
        if (fall) begin
          s_d.state = s_q.reduced ? SUP_RECOVER : SUP_FREE;
          s_d.pre = 25'h0000000;
          s_d.secs = 8'h00;
        end else if (finite && tick && (s_q.secs + 8'h01 >= hold_secs)) begin
          s_d.state = SUP_STUCK;
          s_d.reduced = 1'b1;
          s_d.reset_pulse = 1'b1;
          if (s_q.diag != `DIAG_MAX) begin
            s_d.diag = s_q.diag + 16'h0001;
          end
        end
      end
      SUP_STUCK: begin
        if (fall) begin
          s_d.state = SUP_RECOVER;
          s_d.pre = 25'h0000000;
          s_d.secs = 8'h00;
        end
      end
      SUP_RECOVER: begin
        if (rise) begin
          // a new vehicle restarts the recovery once it leaves
          s_d.state = SUP_OCC;
          s_d.pre = 25'h0000000;
          s_d.secs = 8'h00;
        end else if (tick && (s_q.secs + 8'h01 >= `RECOVERY_SECS)) begin
          s_d.state = SUP_FREE;
          s_d.reduced = 1'b0;
        end
      end
      default: begin
        s_d.state = SUP_FREE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{state: SUP_FREE, occ_prev: 1'b0, pre: 25'h0000000,
               secs: 8'h00, reduced: 1'b0, reset_pulse: 1'b0,
               diag: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign chan_reset = s_q.reset_pulse;
  assign ignore_veh = (s_q.state == SUP_STUCK);
  assign sens_reduced = s_q.reduced;
  assign diag_count = s_q.diag;

endmodule : hold_supervisor

`default_nettype wire

// ---- verilog/loop_vehicle_evaluation.sv ----
/*
  Per-channel vehicle evaluation of a double-loop detector: length
  correction, wrong-way flagging, bus address and hold supervision.
  Assumes vehicle results, occupancy and configuration strobes come
  from logic on ref_clk; only the address switches are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
`include "loop_eval_defs.svh"

module loop_vehicle_evaluation
  import loop_eval_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SEC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] loop_type,
  input wire logic cfg_wr,
  input wire logic [4:0] cfg_len_corr,
  input wire logic [7:0] cfg_min_speed,
  input wire logic [1:0] cfg_dir_mode,
  input wire logic [7:0] cfg_hold_secs,
  input wire logic cfg_hold_inf,
  input wire logic [7:0] cfg_bus_addr,
  input wire logic [2:0] hw_addr_pins,
  input wire logic hw_addr_en,
  input wire logic occupied,
  input wire logic veh_valid,
  input wire veh_in_t veh,
  output logic tel_valid,
  output telegram_t tel,
  output logic svc_valid,
  output svc_line_t svc,
  output logic [7:0] bus_addr,
  output logic [4:0] len_corr_now,
  output logic chan_reset,
  output logic sens_reduced,
  output logic [15:0] hold_diag
);

  typedef struct packed {
    cfg_t cfg;
    logic [2:0] hw_meta;
    logic [2:0] hw_sync;
    logic tel_valid;
    telegram_t tel;
    svc_line_t svc;
    logic [7:0] addr;
  } eval_t;

  eval_t e_q, e_d;
  logic [9:0] real_len_w;
  logic ignore_w;
  logic opposes_w;
  logic too_slow_w;
  logic [4:0] def_corr_w;
  logic [4:0] cfg_corr_w;
  dir_mode_t dir_in_w;

  // stored correction feeds the subtractor
  length_corrector u_len (
    .atten_len(veh.atten_len),
    .len_corr(e_q.cfg.len_corr),
    .real_len(real_len_w)
  );

  hold_supervisor #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_hold (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .occupied(occupied),
    .hold_secs(e_q.cfg.hold_secs),
    .hold_inf(e_q.cfg.hold_inf),
    .chan_reset(chan_reset),
    .ignore_veh(ignore_w),
    .sens_reduced(sens_reduced),
    .diag_count(hold_diag)
  );

  // default correction per loop type
  always_comb begin
    case (loop_type)
      2'd0: def_corr_w = `LEN_CORR_DEF_TYPE0;
      2'd1: def_corr_w = `LEN_CORR_DEF_TYPE1;
      2'd2: def_corr_w = `LEN_CORR_DEF_TYPE2;
      default: def_corr_w = `LEN_CORR_DEF_TYPE3;
    endcase
  end

  // out-of-range writes are clamped, not refused
  assign cfg_corr_w = (cfg_len_corr > `LEN_CORR_MAX) ? `LEN_CORR_MAX
                                                     : cfg_len_corr;

  // an unknown code reads as evaluation off
  always_comb begin
    case (cfg_dir_mode)
      2'b01: dir_in_w = DIR_FWD;
      2'b10: dir_in_w = DIR_REV;
      default: dir_in_w = DIR_OFF;
    endcase
  end

  // order 0 = 1->2, order 1 = 2->1
  always_comb begin
    case (e_q.cfg.dir_mode)
      DIR_FWD: opposes_w = veh.order;
      DIR_REV: opposes_w = !veh.order;
      default: opposes_w = 1'b0;
    endcase
  end

  // reversing service vehicles crawl; they are not wrong-way drivers
  assign too_slow_w = (veh.speed < e_q.cfg.min_speed);

  always_comb begin
    e_d = e_q;
    e_d.tel_valid = 1'b0;

    // address switches are asynchronous pins
    e_d.hw_meta = hw_addr_pins;
    e_d.hw_sync = e_q.hw_meta;

    // a new loop type pulls in its default, overriding any tuning
    if (loop_type != e_q.cfg.loop_type) begin
      e_d.cfg.loop_type = loop_type;
      e_d.cfg.len_corr = def_corr_w;
    end else if (cfg_wr) begin
      e_d.cfg.len_corr = cfg_corr_w;
    end

    // sensitivity deliberately has no field here
    if (cfg_wr) begin
      e_d.cfg.min_speed = cfg_min_speed;
      e_d.cfg.dir_mode = dir_in_w;
      e_d.cfg.hold_secs = cfg_hold_secs;
      e_d.cfg.hold_inf = cfg_hold_inf;
      e_d.cfg.bus_addr = cfg_bus_addr;
    end

    // switch value 0 disables hardware addressing
    if (hw_addr_en && (e_q.hw_sync != 3'b000)) begin
      e_d.addr = {5'b00000, e_q.hw_sync};
    end else begin
      e_d.addr = e_q.cfg.bus_addr;
    end

    // a vehicle still on the loop after a hold reset is dropped
    if (veh_valid && !ignore_w) begin
      e_d.tel_valid = 1'b1;
      e_d.tel.real_len = real_len_w;
      e_d.tel.order = veh.order;
      e_d.tel.speed = veh.speed;
      e_d.tel.wrong_way = opposes_w && !too_slow_w;
      e_d.svc.suffix = veh.order;
      if (opposes_w && !too_slow_w) begin
        e_d.svc.tag = TAG_WRONG;
      end else begin
        e_d.svc.tag = TAG_NORMAL;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      e_q.cfg <= '{loop_type: 2'd0, len_corr: `LEN_CORR_DEF_TYPE0,
                   min_speed: `MIN_SPEED_RST, dir_mode: DIR_OFF,
                   hold_secs: `HOLD_SECS_RST, hold_inf: `HOLD_INF_RST,
                   bus_addr: `BUS_ADDR_RST};
      e_q.hw_meta <= 3'b000;
      e_q.hw_sync <= 3'b000;
      e_q.tel_valid <= 1'b0;
      e_q.tel <= '0;
      e_q.svc <= '{tag: TAG_NORMAL, suffix: 1'b0};
      e_q.addr <= `BUS_ADDR_RST;
    end else begin
      e_q <= e_d;
    end
  end

  assign tel_valid = e_q.tel_valid;
  assign tel = e_q.tel;
  assign svc_valid = e_q.tel_valid;
  assign svc = e_q.svc;
  assign bus_addr = e_q.addr;
  assign len_corr_now = e_q.cfg.len_corr;

endmodule : loop_vehicle_evaluation

`default_nettype wire

// ---- verification/loop_eval_props.sv ----
/* Port checker for loop_vehicle_evaluation.
   Bound to the top module; expects a small SEC_CYCLES in simulation. */
`timescale 1ns/1ns
`default_nettype none
module loop_eval_props
  import loop_eval_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic occupied,
  input wire logic veh_valid,
  input wire veh_in_t veh,
  input wire logic tel_valid,
  input wire telegram_t tel,
  input wire logic svc_valid,
  input wire svc_line_t svc,
  input wire logic [4:0] len_corr_now,
  input wire logic chan_reset,
  input wire logic sens_reduced,
  input wire logic [15:0] hold_diag
);
  localparam int RLO = 4 * SEC_CYCLES - 2;
  localparam int RHI = 4 * SEC_CYCLES + 2;
  logic [9:0] exp_len_q;
  // saturating difference, so a large correction never wraps
  always_ff @(posedge ref_clk) begin
    exp_len_q <= (veh.atten_len > {5'h00, len_corr_now}) ?
      veh.atten_len - {5'h00, len_corr_now} : 10'h000;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_TEL_NEXT: assert property (veh_valid && !occupied && !$past(occupied)
    |=> tel_valid) else $error("vehicle gave no telegram");
  AST_TEL_CAUSE: assert property (tel_valid |-> $past(veh_valid))
    else $error("telegram without vehicle");
  AST_SVC_PAIR: assert property (tel_valid |-> svc_valid &&
    svc.suffix == tel.order && svc.tag == tel.wrong_way)
    else $error("service line disagrees with telegram");
  AST_LEN: assert property (veh_valid && !occupied && !$past(occupied)
    |=> tel.real_len == exp_len_q) else $error("real length wrong");
  AST_CORR_MAX: assert property (len_corr_now <= 5'h14)
    else $error("correction above limit");
  AST_RST_OCC: assert property (chan_reset |-> $past(occupied) ##1
    (!chan_reset && sens_reduced)) else $error("hold reset misbehaves");
  AST_DROP: assert property ($past(chan_reset) && veh_valid && occupied
    |=> !tel_valid) else $error("stuck vehicle reported");
  AST_DIAG: assert property (hold_diag == $past(hold_diag) +
    {15'h0000, chan_reset}) else $error("hold count wrong");
  AST_RECOVER: assert property ($fell(occupied) && sens_reduced
    |-> ##[RLO:RHI] $fell(sens_reduced)) else $error("recovery time");
  cover property (chan_reset);
  cover property (tel_valid && tel.wrong_way);
  cover property ($fell(sens_reduced));
endmodule : loop_eval_props
bind loop_vehicle_evaluation loop_eval_props #(.SEC_CYCLES(SEC_CYCLES))
  i_props (.*);
`default_nettype wire

// ---- verification/tda_model.sv ----
/* Data acquisition receiver: keeps the last telegram and a count.
   Sits on the telegram outputs, same clock as the block. */
`timescale 1ns/1ns
`default_nettype none
module tda_model
  import loop_eval_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tel_valid,
  input wire telegram_t tel,
  output telegram_t rx,
  output logic [15:0] rx_count
);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx <= '0;
      rx_count <= 16'h0000;
    end else if (tel_valid) begin
      rx <= tel;
      rx_count <= rx_count + 16'h0001;
    end
  end
endmodule : tda_model
`default_nettype wire

// ---- verification/loop_vehicle_evaluation_bench.sv ----
/* Self-checking bench for loop_vehicle_evaluation.
   Drives inputs by NBA at rising edges; SEC_CYCLES shortened to 10. */
`timescale 1ns/1ns
`default_nettype none
module loop_vehicle_evaluation_bench;
  import loop_eval_pkg::*;
  localparam int unsigned SECS = 10;
  logic ref_clk, rst_n, cfg_wr, cfg_hold_inf, hw_addr_en, occupied;
  logic veh_valid, tel_valid, svc_valid, chan_reset, sens_reduced;
  logic [1:0] loop_type, cfg_dir_mode;
  logic [4:0] cfg_len_corr, len_corr_now;
  logic [7:0] cfg_min_speed, cfg_hold_secs, cfg_bus_addr, bus_addr;
  logic [2:0] hw_addr_pins;
  logic [15:0] hold_diag, rx_count;
  veh_in_t veh;
  telegram_t tel, rx;
  svc_line_t svc;
  int fail_count, checked, cyc, n;

  loop_vehicle_evaluation #(.SEC_CYCLES(SECS)) i_dut (.*);
  tda_model i_tda (.ref_clk(ref_clk), .rst_n(rst_n), .tel_valid(tel_valid),
    .tel(tel), .rx(rx), .rx_count(rx_count));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // bench needs about 250 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic cfg(input logic [4:0] c, input logic [1:0] dm,
    input logic [7:0] hs, input logic hi);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_len_corr <= c;
    cfg_dir_mode <= dm;
    cfg_hold_secs <= hs;
    cfg_hold_inf <= hi;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    tick(2);
  endtask : cfg
  task automatic car(input logic o, input logic [9:0] a, input logic [7:0] s,
    input logic [9:0] len, input logic ww);
    @(posedge ref_clk);
    veh_valid <= 1'b1;
    veh <= {o, a, s};
    @(posedge ref_clk);
    veh_valid <= 1'b0;
    #1;
    chk("tel_valid", 16'(tel_valid), 16'h0001);
    chk("svc_suffix", 16'(svc.suffix), 16'(o));
    chk("svc_tag", 16'(svc.tag), 16'(ww));
    tick(1);
    chk("real_len", 16'(rx.real_len), 16'(len));
    chk("wrong_way", 16'(rx.wrong_way), 16'(ww));
  endtask : car

  initial begin
    {rst_n, cfg_wr, hw_addr_en, occupied, veh_valid} = 5'h00;
    {loop_type, cfg_dir_mode, cfg_len_corr, cfg_hold_secs} = '0;
    {fail_count, checked, cyc} = '0;
    cfg_hold_inf = 1'b1;
    cfg_min_speed = 8'h14;
    cfg_bus_addr = 8'h22;
    hw_addr_pins = 3'h0;
    veh = '0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    chk("bus_addr", 16'(bus_addr), 16'h0001);
    chk("len_corr", 16'(len_corr_now), 16'h000a);
    car(1'b1, 10'h064, 8'h32, 10'h05a, 1'b0);
    @(posedge ref_clk);
    loop_type <= 2'h2;
    tick(3);
    chk("len_corr", 16'(len_corr_now), 16'h000e);
    cfg(5'h19, 2'h1, 8'h00, 1'b1);
    chk("len_corr", 16'(len_corr_now), 16'h0014);
    chk("bus_addr", 16'(bus_addr), 16'h0022);
    car(1'b0, 10'h00f, 8'h32, 10'h000, 1'b0);
    car(1'b0, 10'h015, 8'h32, 10'h001, 1'b0);
    for (int m = 0; m < 4; m++) begin
      cfg(5'h07, 2'(m), 8'h00, 1'b1);
      for (int o = 0; o < 2; o++) begin
        car(1'(o), 10'h064, 8'h32, 10'h05d,
          1'((m == 1 && o == 1) || (m == 2 && o == 0)));
      end
    end
    cfg(5'h07, 2'h1, 8'h00, 1'b1);
    car(1'b1, 10'h064, 8'h13, 10'h05d, 1'b0);
    car(1'b1, 10'h064, 8'h14, 10'h05d, 1'b1);
    cfg(5'h07, 2'h1, 8'h02, 1'b0);
    @(posedge ref_clk);
    occupied <= 1'b1;
    n = 0;
    while (chan_reset !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk("hold_time", 16'(n >= 20 && n <= 24), 16'h0001);
    chk("hold_diag", hold_diag, 16'h0001);
    // vehicle in the cycle right after the hold reset must vanish
    @(posedge ref_clk);
    veh_valid <= 1'b1;
    @(posedge ref_clk);
    veh_valid <= 1'b0;
    #1;
    chk("dropped", 16'(tel_valid), 16'h0000);
    chk("sens_low", 16'(sens_reduced), 16'h0001);
    @(posedge ref_clk);
    occupied <= 1'b0;
    n = 0;
    while (sens_reduced !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    chk("recovery", 16'(n >= 38 && n <= 44), 16'h0001);
    cfg(5'h07, 2'h1, 8'h02, 1'b1);
    @(posedge ref_clk);
    occupied <= 1'b1;
    tick(80);
    chk("static_hold", hold_diag, 16'h0001);
    chk("static_sens", 16'(sens_reduced), 16'h0000);
    @(posedge ref_clk);
    occupied <= 1'b0;
    @(posedge ref_clk);
    hw_addr_pins <= 3'h5;
    hw_addr_en <= 1'b1;
    tick(5);
    chk("hw_addr", 16'(bus_addr), 16'h0005);
    chk("rx_count", rx_count, 16'h000d);
    results();
  end
endmodule : loop_vehicle_evaluation_bench
`default_nettype wire
